/* aqc_defines.svh */
// Constants for the alarm and position query command set.
// Included by the package, the servo end and the link checker; holds definitions only.
`ifndef AQC_DEFINES_SVH
`define AQC_DEFINES_SVH

// Command codes (two hex digits each)
`define AQC_CMD_READ_STATUS   8'h02
`define AQC_CMD_ALARM_HIST    8'h33
`define AQC_CMD_ALARM_SNAP    8'h35
`define AQC_CMD_CLEAR         8'h82
// Data numbers
`define AQC_DN_CUR_ALARM      8'h00
`define AQC_DN_HIST_NO_LO     8'h10
`define AQC_DN_HIST_NO_HI     8'h15
`define AQC_DN_HIST_TIME_LO   8'h20
`define AQC_DN_HIST_TIME_HI   8'h25
`define AQC_DN_HIST_CLEAR     8'h20
`define AQC_DN_SNAP_LO        8'h80
`define AQC_DN_SNAP_HI        8'h8e
`define AQC_DN_POS_PULSE      8'h90
`define AQC_DN_POS_CMD        8'h91
`define AQC_DN_VERSION        8'h70
// Clear key and no-alarm code
`define AQC_CLEAR_KEY         16'h1ea5
`define AQC_NO_ALARM          16'h00ff
// History depth and snapshot item count
`define AQC_HIST_DEPTH        6
`define AQC_SNAP_ITEMS        15
// Absolute range limits in revolutions
`define AQC_PULSE_OVF_REV     32'd8192
`define AQC_ABS_REV_MAX       32'd32767

`endif

/* aqc_pkg.sv */
// Types shared by both ends of the query command link.
// Assumes aqc_defines.svh sits in the same folder.
`include "aqc_defines.svh"
package aqc_pkg;
  typedef enum logic [1:0] {
    AQC_ACK_DATA,     // Reply carries data
    AQC_ACK_DONE,     // Clear carried out
    AQC_ACK_REJECT    // Unknown request or bad key
  } aqc_status_t;
endpackage

/* aqc_link_if.sv */
// Request/reply channel between host and servo-side interpreter.
// Single clock domain; the testbench joins both modports.
`timescale 1ns/1ps
`default_nettype none
interface aqc_link_if
  import aqc_pkg::*;
  ();
  logic        reqValid;   // Request present
  logic        reqReady;   // Device idle, takes request
  logic [7:0]  reqCmd;     // Command code
  logic [7:0]  reqDataNo;  // Data number
  logic [15:0] reqData;    // Write data (clear key)
  logic        rspValid;   // One-cycle reply pulse
  aqc_status_t rspStatus;  // Reply kind
  logic [31:0] rspData;    // Reply value
  logic [7:0]  rspInfo;    // Data processing info (snapshot)
  modport host (output reqValid, reqCmd, reqDataNo, reqData,
                input reqReady, rspValid, rspStatus, rspData, rspInfo);
  modport dev  (input reqValid, reqCmd, reqDataNo, reqData,
                output reqReady, rspValid, rspStatus, rspData, rspInfo);
endinterface
`default_nettype wire

/* aqc_servo_end.sv */
// Servo-side interpreter for alarm, snapshot, position and version queries.
// Assumes a host on aqc_link_if issuing one request at a time.
`timescale 1ns/1ps
`default_nettype none
`include "aqc_defines.svh"
module aqc_servo_end
  import aqc_pkg::*;
#(
  parameter int          PULSE_W     = 32,            // Pulse position width
  parameter int          PULSES_REV  = 262144,        // Encoder pulses per turn
  parameter logic [31:0] SW_VERSION  = 32'h00000001   // Arbitrary value
) (
  input  wire logic        clock,              // 250 MHz clock
  input  wire logic        rst,                // Async reset, active high
  aqc_link_if.dev          link,               // Host channel
  input  wire logic        alarmEvent,         // Pulse: new alarm raised
  input  wire logic [15:0] alarmCode,          // Code with alarmEvent
  input  wire logic [31:0] hoursRun,           // Whole hours of operation
  input  wire logic [15:0] snapValue [15],     // Live status items
  input  wire logic [7:0]  snapInfo  [15],     // Processing info per item
  input  wire logic [31:0] posPulse,           // Pulse position, signed
  input  wire logic [31:0] posCmd,             // Command-unit position
  input  wire logic [31:0] revCount,           // Signed turns from home
  input  wire logic        absDetectEn,        // Absolute detection selected
  input  wire logic        testModeReq,        // Test operation wanted
  output logic             alarmActive,        // An alarm is standing
  output logic [15:0]      curAlarm,           // Current alarm code
  output logic             alarmResetPulse,    // Same as alarm_reset_input
  output logic             testModeGrant,      // Test operation allowed
  output logic             pulsePosOverflow,   // Pulse count out of range
  output logic             absRangeExceeded    // Beyond tracked revolution range
);

  typedef struct packed {
    logic [5:0][15:0] histCode;
    logic [5:0][31:0] histHour;
    logic [14:0][15:0] snapVal;
    logic [14:0][7:0] snapInf;
    logic [15:0]      curCode;
    logic             rspValid;
    aqc_status_t      rspStatus;
    logic [31:0]      rspData;
    logic [7:0]       rspInfo;
    logic             rstPulse;
  } aqc_dev_state_t;

  aqc_dev_state_t st_r, st_nxt;

  logic [7:0] dn;
  logic [3:0] hidx, sidx;
  logic       keyOk;
  logic [31:0] absRev;

  assign dn    = link.reqDataNo;
  assign hidx  = dn[3:0];
  assign sidx  = dn[3:0];
  assign keyOk = (link.reqData == `AQC_CLEAR_KEY);
  assign absRev = revCount[31] ? (~revCount + 32'd1) : revCount;

  // Next-state: alarm capture, request decode and clears
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rspValid = 1'b0;
    st_nxt.rstPulse = 1'b0;
    // Fresh alarm pushes history and freezes the status snapshot
    if (alarmEvent) begin
      for (int i = `AQC_HIST_DEPTH - 1; i > 0; i--) begin
        st_nxt.histCode[i] = st_r.histCode[i-1];
        st_nxt.histHour[i] = st_r.histHour[i-1];
      end
      st_nxt.histCode[0] = alarmCode;
      st_nxt.histHour[0] = hoursRun;
      st_nxt.curCode     = alarmCode;
      for (int j = 0; j < `AQC_SNAP_ITEMS; j++) begin
        st_nxt.snapVal[j] = snapValue[j];
        st_nxt.snapInf[j] = snapInfo[j];
      end
    end
    if (link.reqValid) begin
      st_nxt.rspValid  = 1'b1;
      st_nxt.rspStatus = AQC_ACK_DATA;
      st_nxt.rspData   = 32'h0;
      st_nxt.rspInfo   = 8'h0;
      unique case (link.reqCmd)
        `AQC_CMD_ALARM_HIST: begin
          if (dn >= `AQC_DN_HIST_NO_LO && dn <= `AQC_DN_HIST_NO_HI)
            st_nxt.rspData = {16'h0, st_r.histCode[hidx]};
          else if (dn >= `AQC_DN_HIST_TIME_LO && dn <= `AQC_DN_HIST_TIME_HI)
            st_nxt.rspData = st_r.histHour[hidx];
          else
            st_nxt.rspStatus = AQC_ACK_REJECT;
        end
        `AQC_CMD_ALARM_SNAP: begin
          if (dn >= `AQC_DN_SNAP_LO && dn <= `AQC_DN_SNAP_HI) begin
            st_nxt.rspData = {16'h0, st_r.snapVal[sidx]};
            st_nxt.rspInfo = st_r.snapInf[sidx];
          end else
            st_nxt.rspStatus = AQC_ACK_REJECT;
        end
        `AQC_CMD_READ_STATUS: begin
          if (dn == `AQC_DN_CUR_ALARM)
            st_nxt.rspData = {16'h0, st_r.curCode};
          else if (dn == `AQC_DN_POS_PULSE)
            st_nxt.rspData = posPulse;
          else if (dn == `AQC_DN_POS_CMD)
            st_nxt.rspData = posCmd;
          else if (dn == `AQC_DN_VERSION)
            st_nxt.rspData = SW_VERSION;
          else
            st_nxt.rspStatus = AQC_ACK_REJECT;
        end
        `AQC_CMD_CLEAR: begin
          // Wrong key leaves all state alone
          if (!keyOk)
            st_nxt.rspStatus = AQC_ACK_REJECT;
          else if (dn == `AQC_DN_HIST_CLEAR) begin
            st_nxt.rspStatus = AQC_ACK_DONE;
            for (int k = 0; k < `AQC_HIST_DEPTH; k++) begin
              st_nxt.histCode[k] = `AQC_NO_ALARM;
              st_nxt.histHour[k] = 32'h0;
            end
            // An alarm raised in the same cycle survives the erase
            if (alarmEvent) begin
              st_nxt.histCode[0] = alarmCode;
              st_nxt.histHour[0] = hoursRun;
            end
          end else if (dn == `AQC_DN_CUR_ALARM) begin
            st_nxt.rspStatus = AQC_ACK_DONE;
            // New alarm in the same cycle wins over the clear
            if (!alarmEvent)
              st_nxt.curCode = `AQC_NO_ALARM;
            st_nxt.rstPulse = 1'b1;
          end else
            st_nxt.rspStatus = AQC_ACK_REJECT;
        end
        default: st_nxt.rspStatus = AQC_ACK_REJECT;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r           <= '0;
      st_r.histCode  <= {`AQC_HIST_DEPTH{`AQC_NO_ALARM}};
      st_r.curCode   <= `AQC_NO_ALARM;
      st_r.rspStatus <= AQC_ACK_DATA;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs; device always accepts, one reply per request next cycle
  assign link.reqReady   = 1'b1;
  assign link.rspValid   = st_r.rspValid;
  assign link.rspStatus  = st_r.rspStatus;
  assign link.rspData    = st_r.rspData;
  assign link.rspInfo    = st_r.rspInfo;
  assign curAlarm        = st_r.curCode;
  assign alarmActive     = (st_r.curCode != `AQC_NO_ALARM);
  assign alarmResetPulse = st_r.rstPulse;
  assign testModeGrant   = testModeReq && !absDetectEn;
  assign absRangeExceeded = absDetectEn && (absRev > `AQC_ABS_REV_MAX);
  // Pulse count is only valid within 8192 turns of home
  assign pulsePosOverflow = (absRev >= `AQC_PULSE_OVF_REV);

endmodule // aqc_servo_end
`default_nettype wire

/* aqc_host_end.sv */
// Host-side issuer: turns user requests into link requests, returns replies.
// Assumes the servo end answers each request exactly once.
`timescale 1ns/1ps
`default_nettype none
module aqc_host_end
  import aqc_pkg::*;
(
  input  wire logic        clock,         // 250 MHz clock
  input  wire logic        rst,           // Async reset, active high
  aqc_link_if.host         link,          // Device channel
  input  wire logic        userValid,     // User request present
  output logic             userReady,     // Host idle
  input  wire logic [7:0]  userCmd,       // Command code
  input  wire logic [7:0]  userDataNo,    // Data number
  input  wire logic [15:0] userData,      // Clear key or data
  input  wire logic        absAlarmSeen,  // Erase alarm or counter warning
  input  wire logic        homeDone,      // Home position set again
  output logic             doneValid,     // Pulse: reply arrived
  output aqc_status_t      doneStatus,    // Reply kind
  output logic [31:0]      doneData,      // Reply value
  output logic [7:0]       doneInfo,      // Processing info
  output logic             needRehome     // Positioning must wait
);

  typedef enum logic [1:0] {H_IDLE, H_REQ, H_WAIT} aqc_hstate_t;

  typedef struct packed {
    aqc_hstate_t fsm;
    logic [7:0]  cmd;
    logic [7:0]  dno;
    logic [15:0] data;
    logic        dv;
    aqc_status_t ds;
    logic [31:0] dd;
    logic [7:0]  di;
    logic        rehome;
  } aqc_host_state_t;

  aqc_host_state_t st_r, st_nxt;

  // Sequencing: one request outstanding at a time
  always_comb begin
    st_nxt    = st_r;
    st_nxt.dv = 1'b0;
    // Re-homing obligation; new alarm wins over home done
    if (absAlarmSeen)
      st_nxt.rehome = 1'b1;
    else if (homeDone)
      st_nxt.rehome = 1'b0;
    unique case (st_r.fsm)
      H_IDLE: begin
        if (userValid) begin
          st_nxt.cmd  = userCmd;
          st_nxt.dno  = userDataNo;
          st_nxt.data = userData;
          st_nxt.fsm  = H_REQ;
        end
      end
      H_REQ: begin
        if (link.reqReady)
          st_nxt.fsm = H_WAIT;
      end
      H_WAIT: begin
        if (link.rspValid) begin
          st_nxt.dv  = 1'b1;
          st_nxt.ds  = link.rspStatus;
          st_nxt.dd  = link.rspData;
          st_nxt.di  = link.rspInfo;
          st_nxt.fsm = H_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r     <= '0;
      st_r.fsm <= H_IDLE;
      st_r.ds  <= AQC_ACK_DATA;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Request held from registers, so fields stay put while valid
  assign link.reqValid  = (st_r.fsm == H_REQ);
  assign link.reqCmd    = st_r.cmd;
  assign link.reqDataNo = st_r.dno;
  assign link.reqData   = st_r.data;
  assign userReady      = (st_r.fsm == H_IDLE);
  assign doneValid      = st_r.dv;
  assign doneStatus     = st_r.ds;
  assign doneData       = st_r.dd;
  assign doneInfo       = st_r.di;
  assign needRehome     = st_r.rehome;

endmodule // aqc_host_end
`default_nettype wire

/* aqc_link_properties.sv */
// Link checker: reply timing and reply kinds for clear, history, snapshot, version and position requests.
// Assumes one clock domain and an instance beside the joined interface.
`timescale 1ns/1ps
`default_nettype none
`include "aqc_defines.svh"
module aqc_link_properties
  import aqc_pkg::*;
#(
  parameter logic [31:0] SW_VERSION = 32'h00000001  // Arbitrary value
) (
  input wire logic        clock,      // Link clock
  input wire logic        rst,        // Async reset, active high
  input wire logic        reqValid,   // Request present
  input wire logic [7:0]  reqCmd,     // Command code
  input wire logic [7:0]  reqDataNo,  // Data number
  input wire logic [15:0] reqData,    // Clear key
  input wire logic        rspValid,   // Reply pulse
  input wire aqc_status_t rspStatus,  // Reply kind
  input wire logic [31:0] rspData     // Reply value
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Take of a keyed clear, and a data reply one edge later
  sequence sClearKey;
    reqValid && reqCmd == 8'h82 && reqData == `AQC_CLEAR_KEY &&
      (reqDataNo == 8'h00 || reqDataNo == 8'h20);
  endsequence
  sequence sDataReply;
    rspValid && rspStatus == AQC_ACK_DATA;
  endsequence
  a_reply_next_edge: assert property (
    reqValid |=> rspValid) else $error("no reply one cycle after request");
  a_no_stray_reply: assert property (
    !reqValid |=> !rspValid) else $error("reply without request");
  a_clear_key_done: assert property (
    sClearKey |=> rspValid && rspStatus == AQC_ACK_DONE) else $error("keyed clear not done");
  a_bad_key_reject: assert property (
    reqValid && reqCmd == 8'h82 && reqData != `AQC_CLEAR_KEY |=> rspStatus == AQC_ACK_REJECT)
    else $error("clear with wrong key not rejected");
  a_hist_range_ok: assert property (
    reqValid && reqCmd == 8'h33 && reqDataNo inside {[8'h10:8'h15], [8'h20:8'h25]}
    |=> sDataReply) else $error("history read not answered with data");
  a_snap_range_ok: assert property (
    reqValid && reqCmd == 8'h35 && reqDataNo inside {[8'h80:8'h8e]} |=> sDataReply)
    else $error("snapshot read not answered with data");
  a_snap_out_reject: assert property (
    reqValid && reqCmd == 8'h35 && reqDataNo == 8'h8f |=> rspStatus == AQC_ACK_REJECT)
    else $error("snapshot index past end accepted");
  a_version_value: assert property (
    reqValid && reqCmd == 8'h02 && reqDataNo == 8'h70 |=> sDataReply ##0 rspData == SW_VERSION)
    else $error("version reply wrong");
  a_pos_reads_data: assert property (
    reqValid && reqCmd == 8'h02 && reqDataNo inside {8'h90, 8'h91} |=> sDataReply)
    else $error("position read not answered with data");
endmodule // aqc_link_properties
`default_nettype wire

/* alarm_and_position_query_commands_tb.sv */
// Bench joining host and servo ends; drives user side and servo inputs.
// Assumes design files and the link checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module alarm_and_position_query_commands_tb;
  import aqc_pkg::*;
  logic clock = 0, rst = 1, userValid = 0, alarmEvent = 0, absDetectEn = 0, testModeReq = 0;
  logic absAlarmSeen = 0, homeDone = 0, userReady, doneValid, needRehome, alarmActive;
  logic alarmResetPulse, testModeGrant, pulsePosOverflow, absRangeExceeded;
  logic [7:0] userCmd = 0, userDataNo = 0, doneInfo, snapInfo [15];
  logic [15:0] userData = 0, alarmCode = 0, curAlarm, snapValue [15];
  logic [31:0] hoursRun = 0, posPulse = 0, posCmd = 0, revCount = 0, doneData;
  aqc_status_t doneStatus;
  int nFail = 0, checks = 0, resets = 0;
  aqc_link_if link ();
  aqc_servo_end i_aqc_servo_end (.clock, .rst, .link, .alarmEvent, .alarmCode, .hoursRun,
    .snapValue, .snapInfo, .posPulse, .posCmd, .revCount, .absDetectEn, .testModeReq,
    .alarmActive, .curAlarm, .alarmResetPulse, .testModeGrant, .pulsePosOverflow,
    .absRangeExceeded);
  aqc_host_end i_aqc_host_end (.clock, .rst, .link, .userValid, .userReady, .userCmd,
    .userDataNo, .userData, .absAlarmSeen, .homeDone, .doneValid, .doneStatus, .doneData,
    .doneInfo, .needRehome);
  aqc_link_properties i_aqc_link_properties (.clock, .rst, .reqValid(link.reqValid),
    .reqCmd(link.reqCmd), .reqDataNo(link.reqDataNo), .reqData(link.reqData),
    .rspValid(link.rspValid), .rspStatus(link.rspStatus), .rspData(link.rspData));
  // Clock, and a tally of reset pulses so a double pulse shows up
  always #2 clock = ~clock;
  always @(posedge clock) if (alarmResetPulse === 1'b1) resets <= resets + 1;
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      nFail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One user request, wait for its reply; data judged only on data replies
  task automatic q(input logic [7:0] c, d, input logic [15:0] w, input aqc_status_t s,
                   input logic [31:0] v);
    int k;
    k = 0;
    @(negedge clock);
    userValid = 1;
    userCmd = c;
    userDataNo = d;
    userData = w;
    @(negedge clock);
    userValid = 0;
    while (doneValid !== 1'b1 && k < 20) begin
      @(negedge clock);
      k++;
    end
    chk("reply arrived", 32'(doneValid), 1);
    chk("host idle", 32'(userReady), 1);
    chk("reply kind", 32'(doneStatus), 32'(s));
    if (s == AQC_ACK_DATA) chk("reply data", doneData, v);
  endtask
  task automatic raise(input logic [15:0] c, input logic [31:0] h);
    @(negedge clock);
    alarmCode = c;
    hoursRun = h;
    alarmEvent = 1;
    @(negedge clock);
    alarmEvent = 0;
  endtask
  // Seven alarms so the oldest must fall out of the six entries
  task automatic t_history();
    q(8'h33, 8'h15, 0, AQC_ACK_DATA, 32'h00ff);
    for (int i = 0; i < 7; i++) raise(16'(16'h0010 + i), 32'h01f0 + i);
    for (int j = 0; j < 6; j++) begin
      q(8'h33, 8'(8'h10 + j), 0, AQC_ACK_DATA, 32'h0016 - j);
      q(8'h33, 8'(8'h20 + j), 0, AQC_ACK_DATA, 32'h01f6 - j);
    end
    $display("history test done");
  endtask
  // Live items change after the alarm; replies must show the capture
  task automatic t_current();
    for (int i = 0; i < 15; i++) snapValue[i] = 16'hffff;
    q(8'h02, 8'h00, 0, AQC_ACK_DATA, 32'h0016);
    chk("alarm standing", alarmActive, 1);
    for (int i = 0; i < 15; i += 14) begin
      q(8'h35, 8'(8'h80 + i), 0, AQC_ACK_DATA, 32'h0a00 + i);
      chk("snapshot info", doneInfo, 8'h40 + i);
    end
    q(8'h35, 8'h8f, 0, AQC_ACK_REJECT, 0);
    q(8'h02, 8'h01, 0, AQC_ACK_REJECT, 0);
    q(8'h33, 8'h16, 0, AQC_ACK_REJECT, 0);
    q(8'h8b, 8'h00, 0, AQC_ACK_REJECT, 0);
    $display("current alarm test done");
  endtask
  task automatic t_clear();
    int n;
    n = resets;
    q(8'h82, 8'h00, 16'h1ea4, AQC_ACK_REJECT, 0);
    chk("alarm kept", curAlarm, 32'h0016);
    q(8'h82, 8'h00, 16'h1ea5, AQC_ACK_DONE, 0);
    chk("reset pulses", resets - n, 1);
    chk("alarm code", curAlarm, 32'h00ff);
    chk("alarm standing", alarmActive, 0);
    q(8'h82, 8'h20, 16'h0000, AQC_ACK_REJECT, 0);
    q(8'h82, 8'h10, 16'h1ea5, AQC_ACK_REJECT, 0);
    q(8'h33, 8'h10, 0, AQC_ACK_DATA, 32'h0016);
    q(8'h82, 8'h20, 16'h1ea5, AQC_ACK_DONE, 0);
    q(8'h33, 8'h10, 0, AQC_ACK_DATA, 32'h00ff);
    q(8'h33, 8'h25, 0, AQC_ACK_DATA, 0);
    $display("clear test done");
  endtask
  // Boundary turn counts either side of both limits
  task automatic t_position();
    logic [31:0] revs [6];
    revs = '{32'h1fff, 32'h2000, 32'hffffe000, 32'h7fff, 32'h8000, 32'hffff8000};
    posPulse = 32'h000186a0;
    posCmd = 32'hfffe7960;
    q(8'h02, 8'h90, 0, AQC_ACK_DATA, 32'h000186a0);
    q(8'h02, 8'h91, 0, AQC_ACK_DATA, 32'hfffe7960);
    q(8'h02, 8'h70, 0, AQC_ACK_DATA, 32'h00000001);
    absDetectEn = 1;
    testModeReq = 1;
    for (int i = 0; i < 6; i++) begin
      @(negedge clock);
      revCount = revs[i];
      #1;
      chk("overflow", pulsePosOverflow, i > 0);
      chk("range", absRangeExceeded, i > 3);
    end
    chk("test grant", testModeGrant, 0);
    absDetectEn = 0;
    #1;
    chk("test grant", testModeGrant, 1);
    $display("position test done");
  endtask
  task automatic t_rehome();
    @(negedge clock);
    absAlarmSeen = 1;
    @(negedge clock);
    absAlarmSeen = 0;
    chk("rehome set", needRehome, 1);
    homeDone = 1;
    @(negedge clock);
    homeDone = 0;
    chk("rehome clear", needRehome, 0);
    $display("rehome test done");
  endtask
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence: reset for eight cycles, then each scenario
  initial begin
    for (int i = 0; i < 15; i++) begin
      snapValue[i] = 16'(16'h0a00 + i);
      snapInfo[i] = 8'(8'h40 + i);
    end
    repeat (8) @(negedge clock);
    rst = 0;
    t_history();
    t_current();
    t_clear();
    t_position();
    t_rehome();
    wrapUp();
  end
  // Watchdog: about thirty times the expected run length
  initial begin
    #20000;
    nFail++;
    wrapUp();
  end
endmodule // alarm_and_position_query_commands_tb
`default_nettype wire
